// file: verilog/acrp_pkg.sv
package acrp_pkg;

  // ----------------------------------------------------------------------
  // Port geometry
  // ----------------------------------------------------------------------
  localparam int unsigned DATA_W   = 8;
  localparam int unsigned ADDR_W   = 8;
  localparam int unsigned NUM_REGS = 148;

  // ----------------------------------------------------------------------
  // Register defaults and bus answers
  // ----------------------------------------------------------------------
  localparam logic [DATA_W-1:0] REG_RESET = 8'h00;
  localparam logic [DATA_W-1:0] UNMAPPED  = 8'h00;

  // ----------------------------------------------------------------------
  // Decoded access kinds
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    ACC_IDLE  = 2'b00,
    ACC_READ  = 2'b01,
    ACC_WRITE = 2'b10
  } acrp_acc_e;

  // Host-side strobes, all active low, as seen on the pins
  typedef struct packed {
    logic              ce_b;
    logic              rd_b;
    logic              wr_b;
    logic [ADDR_W-1:0] addr;
  } acrp_req_s;

endpackage : acrp_pkg

// file: verilog/acrp_decode.sv
`timescale 1ns/1ps
module acrp_decode (
  input  wire acrp_pkg::acrp_req_s req_i,
  output acrp_pkg::acrp_acc_e      acc_o,
  output logic                     drive_o
);

  // ----------------------------------------------------------------------
  // Strobe decode
  // ----------------------------------------------------------------------
  // Write wins whenever the write strobe is low, so holding the read strobe
  // low turns the write strobe into a read/write select.
  always_comb begin
    acc_o   = acrp_pkg::ACC_IDLE;
    drive_o = 1'b0;
    if (!req_i.ce_b) begin
      if (!req_i.wr_b) begin
        acc_o = acrp_pkg::ACC_WRITE;
      end else if (!req_i.rd_b) begin
        acc_o   = acrp_pkg::ACC_READ;
        drive_o = 1'b1;
      end
    end
  end

endmodule : acrp_decode

// file: verilog/acrp_port.sv
`timescale 1ns/1ps
// Behaviour
// - Eight-bit two-way data bus
// - Drive only when selected, reading, not writing
// - Each register has its own flat address
// - Read puts addressed register on bus
// - Write loads addressed register from bus
// - Read held low makes write a select
// - Space holds 148 configuration registers
module acrp_port #(
  parameter int unsigned NUM_REGS = acrp_pkg::NUM_REGS
) (
  input  wire logic                        mclk_i,
  input  wire logic                        rst_b_i,
  input  wire logic                        ce_b_i,
  input  wire logic                        rd_b_i,
  input  wire logic                        wr_b_i,
  input  wire logic [acrp_pkg::ADDR_W-1:0] addr_i,
  input  wire logic [acrp_pkg::DATA_W-1:0] data_i,
  output logic      [acrp_pkg::DATA_W-1:0] data_o,
  output logic                             data_oe_o,
  output logic      [acrp_pkg::DATA_W-1:0] cfg_o [NUM_REGS],
  output logic                             cfg_wr_o
);

  // ----------------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------------
  if (NUM_REGS < 1 || NUM_REGS > (1 << acrp_pkg::ADDR_W)) begin : g_bad_regs
    $error("NUM_REGS does not fit the address space");
  end

  // ----------------------------------------------------------------------
  // Strobe decode
  // ----------------------------------------------------------------------
  acrp_pkg::acrp_req_s req;
  acrp_pkg::acrp_acc_e acc;
  logic                drive;
  logic                hit;

  // Pins gathered into one word for the decoder, plus the mapped-address flag
  assign req = '{ce_b: ce_b_i, rd_b: rd_b_i, wr_b: wr_b_i, addr: addr_i};
  assign hit = 32'(addr_i) < NUM_REGS;

  // Access kind and pad drive come from a purely combinational decode
  acrp_decode u_acrp_decode (
    .req_i   (req),
    .acc_o   (acc),
    .drive_o (drive)
  );

  // ----------------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------------
  logic [acrp_pkg::DATA_W-1:0] regs_q [NUM_REGS];
  logic [acrp_pkg::DATA_W-1:0] regs_d [NUM_REGS];
  logic                        wr_q;
  logic                        wr_d;

  // Clocked write: the register reloads from the bus on every rising edge of mclk_i while the
  // strobe is low, so the value sampled at the last such edge is what sticks.
  always_comb begin
    regs_d = regs_q;
    wr_d   = 1'b0;
    if (acc == acrp_pkg::ACC_WRITE && hit) begin
      regs_d[addr_i[acrp_pkg::ADDR_W-1:0]] = data_i;
      wr_d = 1'b1;
    end
  end

  // Registers clear together; only constants in the reset branch
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      for (int i = 0; i < NUM_REGS; i++) begin
        regs_q[i] <= acrp_pkg::REG_RESET;
      end
      wr_q <= 1'b0;
    end else begin
      regs_q <= regs_d;
      wr_q   <= wr_d;
    end
  end

  // The core sees the registered copy, never the raw bus
  assign cfg_o    = regs_q;
  assign cfg_wr_o = wr_q; // Tells the core a resync is due soon

  // ----------------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------------
  logic [acrp_pkg::DATA_W-1:0] rdata_q;
  logic [acrp_pkg::DATA_W-1:0] rdata_d;
  logic                        oe_q;
  logic                        oe_d;

  // Registered read data costs one cycle of access time but keeps the pad
  // free of decode glitches.
  always_comb begin
    rdata_d = rdata_q;
    oe_d    = drive;
    if (acc == acrp_pkg::ACC_READ) begin
      rdata_d = hit ? regs_q[addr_i] : acrp_pkg::UNMAPPED;
    end
  end

  // Read data and pad enable launch on the same edge, so they always agree
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rdata_q <= acrp_pkg::UNMAPPED;
      oe_q    <= 1'b0;
    end else begin
      rdata_q <= rdata_d;
      oe_q    <= oe_d;
    end
  end

  // Pad side: the wrapper turns the bus around while data_oe_o is high
  assign data_o    = rdata_q;
  assign data_oe_o = oe_q;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  // Packed image of the register file. Sampled-value functions on a whole
  // unpacked array are not taken by every tool, a flat vector is.
  logic [NUM_REGS*acrp_pkg::DATA_W-1:0] regs_flat;

  always_comb begin
    regs_flat = '0;
    for (int i = 0; i < NUM_REGS; i++) begin
      regs_flat[i*acrp_pkg::DATA_W +: acrp_pkg::DATA_W] = regs_q[i];
    end
  end

  // Output enable only ever follows a sampled read
  a_oe_needs_read: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    data_oe_o |-> $past(!ce_b_i && !rd_b_i && wr_b_i))
    else $error("Data bus driven without a read access");

  // Chip enable high leaves the bus and the registers alone
  a_ce_high_quiet: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    ce_b_i |=> !data_oe_o && $stable(regs_flat))
    else $error("Activity while chip enable is high");

  // A mapped write lands in the addressed register
  a_write_loads: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    (!ce_b_i && !wr_b_i && 32'(addr_i) < NUM_REGS) |=> regs_q[$past(addr_i)] == $past(data_i))
    else $error("Write did not load the addressed register");

  // A steady-address read returns the register as it stood
  a_read_data: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    (!ce_b_i && !rd_b_i && wr_b_i && 32'(addr_i) < NUM_REGS && $stable(addr_i))
      |=> data_o == $past(regs_q[addr_i]))
    else $error("Read returned wrong register contents");

  // Both strobes low is a write, never a drive
  a_rw_select: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    (!ce_b_i && !rd_b_i && !wr_b_i) |=> !data_oe_o ##0 cfg_wr_o == (32'($past(addr_i)) < NUM_REGS))
    else $error("Combined select did not act as a write");

  // Unmapped addresses touch no register and raise no write pulse
  a_unmapped_safe: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    (32'(addr_i) >= NUM_REGS) |=> $stable(regs_flat) && !cfg_wr_o)
    else $error("Unmapped address altered a register");

  // Two read cycles in a row keep the bus driven
  a_oe_on_read: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    (!ce_b_i && !rd_b_i && wr_b_i) ##1 (!ce_b_i && !rd_b_i && wr_b_i) |-> data_oe_o)
    else $error("Read access did not drive the bus");

  // A write elsewhere leaves register zero intact
  a_other_regs_kept: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    (!ce_b_i && !wr_b_i && addr_i != 8'h00) |=> regs_q[0] == $past(regs_q[0]))
    else $error("Write disturbed another register");

  // ----------------------------------------------------------------------
  // Checks: read path
  // ----------------------------------------------------------------------
  // Reading never disturbs the register file, even when repeated every
  // cycle by a host that parks on one address
  a_read_keeps_regs: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    (!ce_b_i && !rd_b_i && wr_b_i) |=> $stable(regs_flat))
    else $error("Read access altered a register");

  // An unmapped read still drives the bus, with the fixed filler value,
  // so the host never samples a floating bus
  a_unmapped_read: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    (!ce_b_i && !rd_b_i && wr_b_i && 32'(addr_i) >= NUM_REGS)
      |=> data_oe_o && data_o == acrp_pkg::UNMAPPED)
    else $error("Unmapped read did not return the filler value");

  // Read data holds between reads, so a slow host may sample it late
  // without seeing it move under its feet
  a_rdata_held: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    !(!ce_b_i && !rd_b_i && wr_b_i) |=> $stable(data_o))
    else $error("Read data changed without a read");

  // A write cycle never turns the pad around, or the host would fight
  // the device for the bus
  a_write_no_drive: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    (!ce_b_i && !wr_b_i) |=> !data_oe_o)
    else $error("Bus driven after a write cycle");

  // ----------------------------------------------------------------------
  // Checks: write path
  // ----------------------------------------------------------------------
  // Every mapped write cycle raises the pulse that asks for a resync
  a_write_pulse: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    (!ce_b_i && !wr_b_i && 32'(addr_i) < NUM_REGS) |=> cfg_wr_o)
    else $error("Mapped write gave no write pulse");

  // The pulse never appears on its own; a spurious one would make the
  // core resynchronise for nothing
  a_pulse_needs_write: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    cfg_wr_o |-> $past(!ce_b_i && !wr_b_i && 32'(addr_i) < NUM_REGS))
    else $error("Write pulse without a mapped write");

  // With chip enable high no write pulse may follow
  a_idle_no_pulse: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    ce_b_i |=> !cfg_wr_o)
    else $error("Write pulse while chip enable is high");

endmodule : acrp_port

// file: test/acrp_host_model.sv
`timescale 1ns/1ps
module acrp_host_model (
  input  wire logic           mclk_i,
  output acrp_pkg::acrp_req_s req_o,
  output logic [7:0]          wdata_o,
  output logic                sync_b_o
);
  // Idle bus: chip enable high
  initial begin
    req_o = '{ce_b: 1'b1, rd_b: 1'b1, wr_b: 1'b1, addr: 8'h00};
    wdata_o = 8'h00;
    sync_b_o = 1'b1;
  end
  // One access: driven on a falling edge, held over one rising edge
  task automatic xfer(input logic ce, rd, wr, input logic [7:0] a, d);
    @(negedge mclk_i);
    req_o = '{ce_b: ce, rd_b: rd, wr_b: wr, addr: a};
    wdata_o = wr ? ~d : d; // Not writing: show junk, never stale data
    @(negedge mclk_i);
    req_o.ce_b = 1'b1;
    wdata_o = ~wdata_o;
  endtask : xfer
  // Sync after writes, since the port is not tied to the sample clock
  task automatic sync_pulse();
    @(negedge mclk_i);
    sync_b_o = 1'b0;
    repeat (4) @(negedge mclk_i);
    sync_b_o = 1'b1;
  endtask : sync_pulse
endmodule : acrp_host_model

// file: test/acrp_port_tb.sv
`timescale 1ns/1ps
module acrp_port_tb;
  logic mclk_i = 1'b0;
  logic rst_b_i = 1'b0;
  acrp_pkg::acrp_req_s req;
  logic [7:0] wdata, data_o, cfg [148];
  logic data_oe_o, cfg_wr_o, sync_b;
  int failures = 0;
  int n_compared = 0;
  int cycles = 0;
  // ------------------------------------------------------------
  // Clock, pad resolution and instances
  // ------------------------------------------------------------
  always #5 mclk_i = ~mclk_i;
  acrp_host_model u_acrp_host_model (.mclk_i(mclk_i), .req_o(req), .wdata_o(wdata),
    .sync_b_o(sync_b));
  acrp_port u_acrp_port (.mclk_i(mclk_i), .rst_b_i(rst_b_i), .ce_b_i(req.ce_b),
    .rd_b_i(req.rd_b), .wr_b_i(req.wr_b), .addr_i(req.addr),
    .data_i(data_oe_o ? data_o : wdata), .data_o(data_o), .data_oe_o(data_oe_o),
    .cfg_o(cfg), .cfg_wr_o(cfg_wr_o));
  task automatic chk(input string nm, input logic [7:0] seen, exp);
    n_compared++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic report_and_stop();
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : report_and_stop
  // Hang guard: the whole run needs well under 200 cycles
  always @(posedge mclk_i) begin
    cycles++;
    if (cycles == 2000) begin
      failures++;
      report_and_stop();
    end
  end
  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  logic [7:0] a_list [3] = '{8'h00, 8'h01, 8'h93};
  task automatic t_write_read();
    logic [7:0] a;
    foreach (a_list[i]) begin
      a = a_list[i];
      u_acrp_host_model.xfer(1'b0, 1'b1, 1'b0, a, a ^ 8'h5a);
      chk("wr_pulse", cfg_wr_o, 8'h01);
      chk("cfg", cfg[a], a ^ 8'h5a);
      chk("oe_wr", data_oe_o, 8'h00);
      u_acrp_host_model.xfer(1'b0, 1'b0, 1'b1, a, 8'h00);
      chk("rdata", data_o, a ^ 8'h5a);
      chk("oe_rd", data_oe_o, 8'h01);
      @(negedge mclk_i);
      chk("oe_off", data_oe_o, 8'h00);
    end
    chk("cfg_other", cfg[2], 8'h00);
    u_acrp_host_model.sync_pulse();
    chk("sync_idle", sync_b, 8'h01);
  endtask : t_write_read
  task automatic t_unmapped();
    u_acrp_host_model.xfer(1'b0, 1'b1, 1'b0, 8'h94, 8'hff);
    chk("wr_unmapped", cfg_wr_o, 8'h00);
    u_acrp_host_model.xfer(1'b0, 1'b0, 1'b1, 8'hff, 8'h00);
    chk("rd_unmapped", data_o, acrp_pkg::UNMAPPED);
    chk("oe_unmapped", data_oe_o, 8'h01);
  endtask : t_unmapped
  task automatic t_ce_high();
    u_acrp_host_model.xfer(1'b1, 1'b0, 1'b0, 8'h05, 8'hff);
    chk("ce_wr", cfg_wr_o, 8'h00);
    chk("ce_cfg", cfg[5], acrp_pkg::REG_RESET);
    u_acrp_host_model.xfer(1'b1, 1'b0, 1'b1, 8'h00, 8'h00);
    chk("ce_oe", data_oe_o, 8'h00);
  endtask : t_ce_high
  task automatic t_combined();
    u_acrp_host_model.xfer(1'b0, 1'b0, 1'b0, 8'h09, 8'hc3);
    chk("rw_cfg", cfg[9], 8'hc3);
    chk("rw_oe", data_oe_o, 8'h00);
    u_acrp_host_model.xfer(1'b0, 1'b0, 1'b1, 8'h09, 8'h00);
    chk("rw_rd", data_o, 8'hc3);
    u_acrp_host_model.sync_pulse();
    chk("rw_sync", sync_b, 8'h01);
  endtask : t_combined
  // Registers written before a mid-run reset must come back cleared
  task automatic t_mid_reset();
    u_acrp_host_model.xfer(1'b0, 1'b1, 1'b0, 8'h03, 8'ha5);
    chk("pre_rst_cfg", cfg[3], 8'ha5);
    rst_b_i = 1'b0;
    @(negedge mclk_i);
    chk("rst_cfg", cfg[3], acrp_pkg::REG_RESET);
    chk("rst_rdata", data_o, 8'h00);
    chk("rst_wr", cfg_wr_o, 8'h00);
    rst_b_i = 1'b1;
    u_acrp_host_model.xfer(1'b0, 1'b0, 1'b1, 8'h03, 8'h00);
    chk("post_rst_oe", data_oe_o, 8'h01);
    chk("post_rst_rd", data_o, acrp_pkg::REG_RESET);
  endtask : t_mid_reset
  initial begin
    repeat (10) @(negedge mclk_i);
    rst_b_i = 1'b1;
    chk("rst_oe", data_oe_o, 8'h00);
    t_ce_high();
    t_write_read();
    t_unmapped();
    t_combined();
    t_mid_reset();
    report_and_stop();
  end
endmodule : acrp_port_tb
